//--- inc/pioc_map.svh
`ifndef PIOC_MAP_SVH
`define PIOC_MAP_SVH
`define PIOC_OFS_OWN_EN 8'h00
`define PIOC_OFS_OWN_DIS 8'h04
`define PIOC_OFS_OWN_STS 8'h08
`define PIOC_OFS_DIR_EN 8'h10
`define PIOC_OFS_DIR_DIS 8'h14
`define PIOC_OFS_DIR_STS 8'h18
`define PIOC_OFS_FLT_EN 8'h20
`define PIOC_OFS_FLT_DIS 8'h24
`define PIOC_OFS_FLT_STS 8'h28
`define PIOC_OFS_LVL_SET 8'h30
`define PIOC_OFS_LVL_CLR 8'h34
`define PIOC_OFS_LVL_STS 8'h38
`define PIOC_OFS_PIN_RD 8'h3C
`define PIOC_OFS_IRQ_EN 8'h40
`define PIOC_OFS_IRQ_DIS 8'h44
`define PIOC_OFS_IRQ_MASK 8'h48
`define PIOC_OFS_IRQ_STS 8'h4C
`define PIOC_OFS_OD_EN 8'h50
`define PIOC_OFS_OD_DIS 8'h54
`define PIOC_OFS_OD_STS 8'h58
`define PIOC_BASE_FIRST 32'hFFFEC000
`define PIOC_BASE_SECOND 32'hFFFF0000
`define PIOC_LINES_FIRST 32'h3FFFFFFF
`define PIOC_LINES_SECOND 32'h0FFFFFFF
`define PIOC_MUX_FIRST 32'h3FFFFFFF
`define PIOC_MUX_SECOND 32'h0FFE0007
`define PIOC_FILT_CYCLES 2
`endif

//--- inc/pioc_pkg.sv
package pioc_pkg;
   typedef logic [31:0] pioc_word_t;
   typedef struct packed {
      logic [2:0] sync;
      logic stable;
   } pioc_sync_t;
endpackage

//--- rtl/pioc_ctrl.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "pioc_map.svh"
// What this block does
// (R1) two instances (30 and 28 lines) give 58 lines, each with one interrupt output
// (R2) after reset every pin is general-purpose input, driver off
// (R3) ownership enable/disable writes select owner; status shows it
// (R4) dedicated pins ignore ownership writes and read owner as one
// (R5) peripheral input reads zero while general-purpose owns the pin
// (R6) every line is bidirectional in general-purpose mode
// (R7) direction set/clear, readable, only matters under general-purpose control
// (R8) drive level set/clear, readable, drives the output pin
// (R9) general-purpose input pins are not driven
// (R10) peripheral-owned pins take level and drive from the peripheral
// (R11) pin readback gives synchronized pin levels, after the glitch filter where it is enabled
// (R12) per-pin glitch filter enable/disable, readable, in any ownership
// (R13) interrupt enable/disable set and clear the mask
// (R14) any change of a pin's synchronized, filtered level sets its status bit
// (R15) interrupt output is high when a status bit is unmasked
// (R16) reading interrupt status returns it and clears it
// (R17) 32-bit registers; undefined lines ignore writes, read zero
// (R18) open-drain pins only drive low
// (R19) open-drain enable/disable, readable, in any ownership
// (R20) software enables the controller clock before accessing it
// (R21) first instance bits 0..29 carry timer, interrupt, usart and spi
// (R22) registers sit at word offsets 0x00 to 0x58
// (R23) instances based at two fixed peripheral addresses
// (R24) second instance implements bits 0..27
// (R25) set and clear writes act only on bits written one
// (R26) change detection compares filtered sample with previous one
// (R27) filter passes a level after two stable cycles
module pioc_ctrl #(
   parameter logic [31:0] LINES = `PIOC_LINES_FIRST, // R21 R24
   parameter logic [31:0] MUXED = `PIOC_MUX_FIRST // R4 R21
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [31:0] i_pin,
   output logic [31:0] o_pin,
   output logic [31:0] o_pin_oe,
   input wire logic [31:0] i_per_out,
   input wire logic [31:0] i_per_oe,
   output logic [31:0] o_per_in,
   output logic o_irq
);
   typedef struct packed {
      pioc_pkg::pioc_word_t own;
      pioc_pkg::pioc_word_t dir;
      pioc_pkg::pioc_word_t flt;
      pioc_pkg::pioc_word_t lvl;
      pioc_pkg::pioc_word_t msk;
      pioc_pkg::pioc_word_t sts;
      pioc_pkg::pioc_word_t od;
      pioc_pkg::pioc_word_t prev;
      logic primed;
      pioc_pkg::pioc_word_t rdata;
      pioc_pkg::pioc_word_t pin;
      pioc_pkg::pioc_word_t oe;
      pioc_pkg::pioc_word_t per_in;
      logic irq;
   } pioc_state_t;
   pioc_state_t s_q, s_d;
   pioc_pkg::pioc_word_t lvl_in;
   pioc_pkg::pioc_word_t wmask;
   pioc_pkg::pioc_word_t change;
   pioc_pkg::pioc_word_t lvl_out;
   pioc_pkg::pioc_word_t drv_en;

   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_line
         if (LINES[g]) begin : g_impl
            pioc_pin_filter u_flt (
               .i_clk_sys(i_clk_sys),
               .i_rst_n(i_rst_n),
               .i_pin(i_pin[g]),
               .i_filt_en(s_q.flt[g]), // R12
               .o_level(lvl_in[g])
            );
         end else begin : g_none
            assign lvl_in[g] = 1'b0; // R17
         end
      end
   endgenerate

   function automatic pioc_pkg::pioc_word_t set_clr(input pioc_pkg::pioc_word_t cur,
         input logic set, input logic clr, input pioc_pkg::pioc_word_t bits);
      pioc_pkg::pioc_word_t r;
      r = cur;
      if (set) begin
         r = cur | bits; // R25
      end else if (clr) begin
         r = cur & ~bits; // R25
      end
      return r;
   endfunction

   always_comb begin
      s_d = s_q;
      wmask = i_wdata & LINES; // R17
      change = s_q.primed ? (lvl_in ^ s_q.prev) : 32'h0000_0000; // R26
      s_d.prev = lvl_in;
      s_d.primed = 1'b1;
      // R3 R4: only muxed bits change owner
      s_d.own = set_clr(s_q.own, i_wr && i_addr == `PIOC_OFS_OWN_EN,
            i_wr && i_addr == `PIOC_OFS_OWN_DIS, wmask & MUXED);
      s_d.dir = set_clr(s_q.dir, i_wr && i_addr == `PIOC_OFS_DIR_EN,
            i_wr && i_addr == `PIOC_OFS_DIR_DIS, wmask); // R7
      s_d.flt = set_clr(s_q.flt, i_wr && i_addr == `PIOC_OFS_FLT_EN,
            i_wr && i_addr == `PIOC_OFS_FLT_DIS, wmask); // R12
      s_d.lvl = set_clr(s_q.lvl, i_wr && i_addr == `PIOC_OFS_LVL_SET,
            i_wr && i_addr == `PIOC_OFS_LVL_CLR, wmask); // R8
      s_d.msk = set_clr(s_q.msk, i_wr && i_addr == `PIOC_OFS_IRQ_EN,
            i_wr && i_addr == `PIOC_OFS_IRQ_DIS, wmask); // R13
      s_d.od = set_clr(s_q.od, i_wr && i_addr == `PIOC_OFS_OD_EN,
            i_wr && i_addr == `PIOC_OFS_OD_DIS, wmask); // R19

      // offsets are relative to the instance base; decoding ignores the base
      s_d.rdata = 32'h0000_0000; // R22 R23
      if (i_rd) begin
         if (i_addr == `PIOC_OFS_OWN_STS) begin
            s_d.rdata = s_q.own; // R3 R4
         end else if (i_addr == `PIOC_OFS_DIR_STS) begin
            s_d.rdata = s_q.dir;
         end else if (i_addr == `PIOC_OFS_FLT_STS) begin
            s_d.rdata = s_q.flt;
         end else if (i_addr == `PIOC_OFS_LVL_STS) begin
            s_d.rdata = s_q.lvl;
         end else if (i_addr == `PIOC_OFS_PIN_RD) begin
            s_d.rdata = lvl_in; // R11
         end else if (i_addr == `PIOC_OFS_IRQ_MASK) begin
            s_d.rdata = s_q.msk;
         end else if (i_addr == `PIOC_OFS_IRQ_STS) begin
            s_d.rdata = s_q.sts; // R16
         end else if (i_addr == `PIOC_OFS_OD_STS) begin
            s_d.rdata = s_q.od;
         end
      end
      // a change arriving on the clearing read survives
      if (i_rd && i_addr == `PIOC_OFS_IRQ_STS) begin
         s_d.sts = change & LINES; // R16
      end else begin
         s_d.sts = (s_q.sts | change) & LINES; // R14
      end

      // R6 R7 R9 R10: owner picks source of level and enable
      lvl_out = (s_q.own & s_q.lvl) | (~s_q.own & i_per_out);
      drv_en = (s_q.own & s_q.dir) | (~s_q.own & i_per_oe);
      // R18: open-drain drives only low
      s_d.oe = (drv_en & ~(s_q.od & lvl_out)) & LINES;
      s_d.pin = lvl_out & ~s_q.od & LINES;
      s_d.per_in = lvl_in & ~s_q.own & MUXED; // R5 R12
      s_d.irq = |(s_d.sts & s_q.msk); // R15
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
         s_q.own <= LINES; // R2
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_pin = s_q.pin;
   assign o_pin_oe = s_q.oe;
   assign o_per_in = s_q.per_in;
   assign o_irq = s_q.irq; // R1
endmodule

//--- rtl/pioc_pin_filter.sv
`timescale 1ns/10ps
`include "pioc_map.svh"
module pioc_pin_filter (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_pin,
   input wire logic i_filt_en,
   output logic o_level
);
   typedef struct packed {
      logic [2:0] sync;
      logic cand;
      logic [1:0] cnt;
      logic level;
   } pioc_flt_t;
   pioc_flt_t s_q, s_d;
   logic agreed;
   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], i_pin};
      // the first stage feeds only the second
      // until the second and third stages agree, the last agreed candidate value (cand) holds
      agreed = s_q.cand;
      if (s_q.sync[1] == s_q.sync[2]) begin
         agreed = s_q.sync[1];
      end
      if (!i_filt_en) begin
         s_d.level = agreed;
         s_d.cand = agreed;
         s_d.cnt = 2'h0;
      end else if (agreed != s_q.cand) begin
         s_d.cand = agreed;
         s_d.cnt = 2'h1;
      end else if (s_q.cnt < 2'(`PIOC_FILT_CYCLES)) begin
         s_d.cnt = s_q.cnt + 2'h1;
      end else begin
         s_d.level = s_q.cand; // R27
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign o_level = s_q.level;
endmodule

//--- tb/pioc_ctrl_bench.sv
`timescale 1ns/10ps
`include "pioc_map.svh"
module pioc_ctrl_bench;
   localparam logic [31:0] LN = `PIOC_LINES_SECOND;
   localparam logic [31:0] MX = `PIOC_MUX_SECOND;
   localparam logic [31:0] F = 32'hFFFFFFFF;
   logic c = 1'b0, r_n = 1'b0, wr = 1'b0, rd = 1'b0, irq;
   logic [7:0] ad = 8'h00;
   logic [31:0] wd = 32'h0, po = 32'h0, pe = 32'h0, ext = 32'h0, eoe = 32'h0;
   logic [31:0] rdat, pin, opin, oe, pin_per, d, e, v, x, m, y;
   logic [7:0] rb [6] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58};
   logic [7:0] sb [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50};
   logic [7:0] ub [4] = '{8'h00, 8'h0C, 8'h5C, 8'h60};
   int n_fail = 0, samples_checked = 0, cyc = 0;
   pioc_ctrl #(.LINES(LN), .MUXED(MX)) uut (.i_clk_sys(c), .i_rst_n(r_n), .i_addr(ad), .i_wdata(wd),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_pin(pin), .o_pin(opin), .o_pin_oe(oe), .i_per_out(po),
      .i_per_oe(pe), .o_per_in(pin_per), .o_irq(irq));
   pioc_pins far (.i_pin(opin), .i_oe(oe), .i_ext(ext), .i_ext_oe(eoe), .o_level(pin));
   initial forever #4 c = ~c;
   task automatic chk(input string s, input logic [31:0] xe, input logic [31:0] g);
      samples_checked++;
      if (g !== xe) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", s, xe, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge c);
      #1;
   endtask
   task automatic wr_r(input logic [7:0] a, input logic [31:0] dd);
      @(posedge c);
      wr <= 1'b1;
      ad <= a;
      wd <= dd;
      @(posedge c);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] xe);
      @(posedge c);
      rd <= 1'b1;
      ad <= a;
      @(posedge c);
      rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), xe, rdat);
   endtask
   task automatic rd_r(input logic [7:0] a);
      @(posedge c);
      rd <= 1'b1;
      ad <= a;
      @(posedge c);
      rd <= 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge c) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      void'($urandom(32'h87353705));
      repeat (4) @(posedge c);
      #2 r_n = 1'b1;
      foreach (rb[i]) rchk(rb[i], i == 0 ? LN : 32'h0);
      foreach (sb[i]) begin
         m = sb[i] == 8'h00 ? MX : LN;
         x = sb[i] == 8'h00 ? LN : 32'h0;
         repeat (3) begin
            v = $urandom;
            e = $urandom;
            wr_r(sb[i], v);
            wr_r(sb[i] + 8'h04, e);
            x = (x | (v & m)) & ~(e & m);
            rchk(sb[i] + 8'h08, x);
         end
         // park every group in its idle setting so later checks start clean
         wr_r(sb[i] == 8'h00 ? 8'h00 : sb[i] + 8'h04, F);
      end
      v = $urandom;
      wr_r(8'h30, v);
      wr_r(8'h10, F);
      wt(8);
      chk("oe", LN, oe);
      chk("pin", v & LN, opin);
      rchk(8'h3C, v & LN);
      wr_r(8'h50, F);
      wt(2);
      chk("od oe", ~v & LN, oe);
      wr_r(8'h54, F);
      wr_r(8'h14, F);
      @(posedge c);
      e = $urandom;
      ext <= e;
      eoe <= F;
      wt(8);
      chk("oe in", 32'h0, oe);
      chk("per in", 32'h0, pin_per);
      rchk(8'h3C, e & LN);
      wr_r(8'h04, F);
      @(posedge c);
      x = $urandom;
      m = $urandom;
      po <= x;
      pe <= m;
      wt(8);
      y = ((x & m & MX) | (e & ~(m & MX))) & LN;
      chk("per oe", m & MX, oe);
      chk("per lvl", x & m & MX, opin & oe);
      chk("per in", y & MX, pin_per);
      rchk(8'h3C, y);
      wr_r(8'h50, F);
      wt(2);
      chk("od per", m & ~x & MX, oe);
      wr_r(8'h54, F);
      wr_r(8'h00, F);
      wt(8);
      rd_r(8'h4C);
      wt(1);
      rchk(8'h4C, 32'h0);
      wr_r(8'h40, 32'h00000020);
      @(posedge c);
      ext <= ext ^ 32'h00000020;
      wt(8);
      chk("irq", 32'h1, {31'h0, irq});
      rchk(8'h4C, 32'h00000020);
      wt(1);
      chk("irq clr", 32'h0, {31'h0, irq});
      rchk(8'h4C, 32'h0);
      wr_r(8'h44, 32'h00000020);
      @(posedge c);
      ext <= ext ^ 32'h00000020;
      wt(8);
      chk("irq off", 32'h0, {31'h0, irq});
      rchk(8'h4C, 32'h00000020);
      wr_r(8'h20, 32'h00000020);
      @(posedge c);
      ext <= ext ^ 32'h00000020;
      @(posedge c);
      ext <= ext ^ 32'h00000020;
      wt(8);
      rchk(8'h4C, 32'h0);
      @(posedge c);
      ext <= ext ^ 32'h00000020;
      wt(8);
      rchk(8'h4C, 32'h00000020);
      foreach (ub[i]) rchk(ub[i], 32'h0);
      test_done();
   end
endmodule
bind pioc_ctrl pioc_props #(.LINES(LINES), .MUXED(MUXED)) props_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_oe(o_pin_oe), .o_per_in(o_per_in));

//--- tb/pioc_pins.sv
`timescale 1ns/10ps
module pioc_pins (
   input wire logic [31:0] i_pin,
   input wire logic [31:0] i_oe,
   input wire logic [31:0] i_ext,
   input wire logic [31:0] i_ext_oe,
   output logic [31:0] o_level
);
   // lines nobody drives float up through the board pull-up
   assign o_level = (i_oe & i_pin) | (~i_oe & i_ext_oe & i_ext) | (~i_oe & ~i_ext_oe);
endmodule

//--- tb/pioc_props.sv
`timescale 1ns/10ps
module pioc_props #(
   parameter logic [31:0] LINES = 32'h0,
   parameter logic [31:0] MUXED = 32'h0
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [31:0] o_pin_oe,
   input wire logic [31:0] o_per_in
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0) else $error("rdata not idle");
   a_undef_zero: assert property ((o_rdata & ~LINES) == 32'h0) else $error("undefined bit read");
   a_undef_drive: assert property ((o_pin_oe & ~LINES) == 32'h0) else $error("undefined bit driven");
   a_dedic_per: assert property ((o_per_in & ~MUXED) == 32'h0) else $error("dedicated per input");
   a_dedic_own: assert property (i_rd && i_addr == 8'h08 |=>
      (o_rdata & LINES & ~MUXED) == (LINES & ~MUXED)) else $error("dedicated owner");
   a_wonly_zero: assert property (i_rd && !i_addr[3] && i_addr < 8'h58 |=> o_rdata == 32'h0)
      else $error("write-only read");
   a_resv_zero: assert property (i_rd && (i_addr >= 8'h5C || i_addr == 8'h0C || i_addr == 8'h1C
      || i_addr == 8'h2C) |=> o_rdata == 32'h0) else $error("reserved read");
   a_reset_input: assert property ($rose(i_rst_n) |-> o_pin_oe == 32'h0) else $error("drive at reset");
endmodule
